// ==== rtl/pwm_meter.sv ====
/*
 Multi-channel pulse width meter: APB register file, per-channel
 edge records, snapshots and clear-on-read completion flags.
 Assumes tick_count is a free-running 0.4 us counter in the pclk
 domain and pulse_in comes straight from asynchronous pins.
*/
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module pwm_meter import pwm_pkg::*; (
	// Clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Time base and pulse pins
	input  wire logic [31:0]       tick_count,
	input  wire logic [NCH-1:0]    pulse_in
);

	typedef struct packed {
		logic                run;
		logic [CH_W-1:0]     sel;
		logic [31:0]         conv;
		logic [31:0]         rdata;
		pwm_rec_t            snap;
		pwm_rec_t [NCH-1:0]  rec;
	} pwm_state_t;

	pwm_state_t        st;
	pwm_state_t        next_st;
	logic [NCH-1:0]    lvl;
	logic [NCH-1:0]    rise;
	logic [NCH-1:0]    fall;
	logic              setup;
	logic              access;
	logic              mapped;
	logic              snap_go;
	logic              sel_edge;
	logic [31:0]       rd_val;
	logic [31:0]       elapsed;
	logic [FLAG_W-1:0] clr_sel;
	pwm_rec_t          sel_rec;

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	pwm_edge u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.pin     (pulse_in),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	// ------------------------------------------------------------
	// APB phases
	// ------------------------------------------------------------
	assign setup    = psel & ~penable;
	assign access   = psel & penable;
	assign sel_rec  = st.rec[st.sel];
	assign elapsed  = tick_diff(tick_count, sel_rec.stamp);
	assign snap_go  = access & pwrite & (paddr == REG_SNAP_CMD) & pwdata[SNAP_GO_BIT];
	assign sel_edge = st.run & (rise[st.sel] | fall[st.sel]);

	// Zero wait states; read data is latched in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata  = st.rdata;

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	always_comb begin
		rd_val = WORD_RST;
		mapped = 1'b1;
		case (paddr)
			REG_CTRL: begin
				rd_val[CTRL_RUN_BIT] = st.run;
			end
			REG_CHSEL: begin
				rd_val[CH_W-1:0] = st.sel;
			end
			REG_SNAP_CMD: begin
				rd_val = WORD_RST;
			end
			REG_SNAP_STAMP: begin
				rd_val = st.snap.stamp;
			end
			REG_SNAP_STATE: begin
				rd_val[FLAG_W-1:0]    = st.snap.flags;
				rd_val[SNAP_LEVEL_BIT] = st.snap.level;
			end
			REG_SNAP_HIGH: begin
				rd_val = st.snap.high_width;
			end
			REG_SNAP_LOW: begin
				rd_val = st.snap.low_width;
			end
			REG_FLAGS_ANY: begin
				rd_val[FLAG_W-1:0] = sel_rec.flags;
			end
			REG_FLAGS_HIGH: begin
				if (sel_rec.flags[FLAG_HIGH_BIT]) begin
					rd_val[FLAG_W-1:0] = sel_rec.flags;
				end
			end
			REG_FLAGS_LOW: begin
				if (sel_rec.flags[FLAG_LOW_BIT]) begin
					rd_val[FLAG_W-1:0] = sel_rec.flags;
				end
			end
			REG_HIGH_WIDTH: begin
				rd_val = sel_rec.high_width;
			end
			REG_LOW_WIDTH: begin
				rd_val = sel_rec.low_width;
			end
			REG_ELAPSED: begin
				rd_val = elapsed;
			end
			REG_LEVEL: begin
				rd_val[0] = sel_rec.level;
			end
			REG_CONV: begin
				rd_val = ticks_to_us(st.conv);
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		clr_sel = '0;
		// Capture once per transfer so a read sees one instant
		if (setup) begin
			next_st.rdata = rd_val;
		end
		if (access && pwrite) begin
			case (paddr)
				REG_CTRL: begin
					next_st.run = pwdata[CTRL_RUN_BIT];
				end
				REG_CHSEL: begin
					next_st.sel = pwdata[CH_W-1:0];
				end
				REG_SNAP_CMD: begin
					if (pwdata[SNAP_GO_BIT]) begin
						next_st.snap = sel_rec;
						clr_sel      = sel_rec.flags;
					end
				end
				REG_CONV: begin
					next_st.conv = pwdata;
				end
				default: begin
					next_st.conv = st.conv;
				end
			endcase
		end
		// Clear only what was reported, so a late pulse is not lost
		if (access && !pwrite) begin
			case (paddr)
				REG_FLAGS_ANY: begin
					clr_sel = st.rdata[FLAG_W-1:0];
				end
				REG_FLAGS_HIGH: begin
					clr_sel[FLAG_HIGH_BIT] = st.rdata[FLAG_HIGH_BIT];
				end
				REG_FLAGS_LOW: begin
					clr_sel[FLAG_LOW_BIT] = st.rdata[FLAG_LOW_BIT];
				end
				default: begin
					clr_sel = '0;
				end
			endcase
		end
		for (int i = 0; i < NCH; i++) begin
			if (!st.run) begin
				// Stopped: records released, kept aligned for restart
				next_st.rec[i]       = '0;
				next_st.rec[i].stamp = tick_count;
				next_st.rec[i].level = lvl[i];
			end else begin
				if (i == int'(st.sel)) begin
					next_st.rec[i].flags = st.rec[i].flags & ~clr_sel;
				end
				// Old record already copied above; update lands after it
				if (rise[i] || fall[i]) begin
					next_st.rec[i].stamp = tick_count;
					next_st.rec[i].level = rise[i];
					if (fall[i]) begin
						next_st.rec[i].high_width = tick_diff(tick_count, st.rec[i].stamp);
						next_st.rec[i].flags[FLAG_HIGH_BIT] = 1'b1;
					end else begin
						next_st.rec[i].low_width = tick_diff(tick_count, st.rec[i].stamp);
						next_st.rec[i].flags[FLAG_LOW_BIT] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st     <= '0;
			st.run <= RUN_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic any_flags;
	always_comb begin
		any_flags = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			any_flags = any_flags | (|st.rec[i].flags);
		end
	end

	property p_stop_clears;
		(ce && !st.run) |=> !any_flags;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("flags kept while stopped");

	property p_snap_copy;
		(ce && snap_go) |=> (st.snap == $past(sel_rec));
	endproperty
	a_snap_copy: assert property (p_snap_copy) else $error("snapshot differs from record");

	property p_snap_clear;
		(ce && snap_go && !sel_edge) |=> (sel_rec.flags == '0);
	endproperty
	a_snap_clear: assert property (p_snap_clear) else $error("flags left after snapshot");

	property p_snap_atomic;
		(ce && snap_go && sel_edge) |=>
			(st.snap.stamp == $past(sel_rec.stamp)) && (sel_rec.stamp == $past(tick_count));
	endproperty
	a_snap_atomic: assert property (p_snap_atomic) else $error("snapshot torn by edge");

	property p_flag_read;
		(ce && setup && (paddr == REG_FLAGS_ANY)) |=> (st.rdata == {30'h0, $past(sel_rec.flags)});
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read value wrong");

	property p_any_clear;
		(ce && access && !pwrite && (paddr == REG_FLAGS_ANY) && !sel_edge)
			|=> ((sel_rec.flags & $past(st.rdata[FLAG_W-1:0])) == '0);
	endproperty
	a_any_clear: assert property (p_any_clear) else $error("flag read did not clear");

	property p_high_read;
		(ce && setup && (paddr == REG_FLAGS_HIGH) && !sel_rec.flags[FLAG_HIGH_BIT])
			|=> (st.rdata == WORD_RST);
	endproperty
	a_high_read: assert property (p_high_read) else $error("high read not zero");

	property p_high_clear;
		(ce && access && !pwrite && (paddr == REG_FLAGS_HIGH) && st.rdata[FLAG_HIGH_BIT] && !sel_edge)
			|=> !sel_rec.flags[FLAG_HIGH_BIT] && (sel_rec.flags[FLAG_LOW_BIT] == $past(sel_rec.flags[FLAG_LOW_BIT]));
	endproperty
	a_high_clear: assert property (p_high_clear) else $error("high clear wrong");

	property p_low_clear;
		(ce && access && !pwrite && (paddr == REG_FLAGS_LOW) && st.rdata[FLAG_LOW_BIT] && !sel_edge)
			|=> !sel_rec.flags[FLAG_LOW_BIT] && (sel_rec.flags[FLAG_HIGH_BIT] == $past(sel_rec.flags[FLAG_HIGH_BIT]));
	endproperty
	a_low_clear: assert property (p_low_clear) else $error("low clear wrong");

	property p_high_width;
		(ce && st.run && fall[0])
			|=> (st.rec[0].high_width == $past(tick_count) - $past(st.rec[0].stamp)) && st.rec[0].flags[FLAG_HIGH_BIT];
	endproperty
	a_high_width: assert property (p_high_width) else $error("high width wrong");

	property p_low_width;
		(ce && st.run && rise[0])
			|=> (st.rec[0].low_width == $past(tick_count) - $past(st.rec[0].stamp)) && st.rec[0].flags[FLAG_LOW_BIT];
	endproperty
	a_low_width: assert property (p_low_width) else $error("low width wrong");

	property p_elapsed;
		(ce && setup && (paddr == REG_ELAPSED)) |=> (st.rdata == $past(elapsed));
	endproperty
	a_elapsed: assert property (p_elapsed) else $error("elapsed read wrong");

	property p_conv;
		(ce && setup && (paddr == REG_CONV)) |=> (st.rdata == ticks_to_us(st.conv));
	endproperty
	a_conv: assert property (p_conv) else $error("conversion wrong");

	c_snapshot: cover property ((ce && snap_go) ##1 (st.snap.flags != '0));
	c_high_pulse: cover property ((ce && st.run && rise[0]) ##[1:50] (ce && fall[0]));
	c_flag_read: cover property (ce && access && (paddr == REG_FLAGS_ANY) && (st.rdata != WORD_RST));
	c_stop: cover property (st.run ##1 !st.run);

endmodule

// ==== rtl/pwm_pkg.sv ====
/*
 Shared constants, record layout and helper functions of the
 multi-channel pulse width meter.
 Assumes a 32-bit APB data path and a 32-bit free-running tick.
*/
package pwm_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NCH    = 8;
	localparam int CH_W   = 3;
	localparam int ADDR_W = 8;
	localparam int FLAG_W = 2;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CHSEL      = 8'h04;
	localparam logic [ADDR_W-1:0] REG_SNAP_CMD   = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SNAP_STAMP = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_SNAP_STATE = 8'h10;
	localparam logic [ADDR_W-1:0] REG_FLAGS_ANY  = 8'h14;
	localparam logic [ADDR_W-1:0] REG_FLAGS_HIGH = 8'h18;
	localparam logic [ADDR_W-1:0] REG_FLAGS_LOW  = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_HIGH_WIDTH = 8'h20;
	localparam logic [ADDR_W-1:0] REG_LOW_WIDTH  = 8'h24;
	localparam logic [ADDR_W-1:0] REG_ELAPSED    = 8'h28;
	localparam logic [ADDR_W-1:0] REG_LEVEL      = 8'h2c;
	localparam logic [ADDR_W-1:0] REG_SNAP_HIGH  = 8'h30;
	localparam logic [ADDR_W-1:0] REG_SNAP_LOW   = 8'h34;
	localparam logic [ADDR_W-1:0] REG_CONV       = 8'h38;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int         CTRL_RUN_BIT   = 0;
	localparam int         SNAP_GO_BIT    = 0;
	localparam int         SNAP_LEVEL_BIT = 8;
	localparam int         FLAG_LOW_BIT   = 0;
	localparam int         FLAG_HIGH_BIT  = 1;
	localparam logic       RUN_RST        = 1'b0;
	localparam logic [31:0] WORD_RST      = 32'h0000_0000;

	// ------------------------------------------------------------
	// Tick timing: one tick is 400 ns, i.e. 2/5 us
	// ------------------------------------------------------------
	localparam int          TICK_NS = 400;
	localparam logic [34:0] US_NUM  = 35'h2;
	localparam logic [34:0] US_DEN  = 35'h5;

	typedef struct packed {
		logic [31:0]       stamp;
		logic              level;
		logic [31:0]       high_width;
		logic [31:0]       low_width;
		logic [FLAG_W-1:0] flags;
	} pwm_rec_t;

	function automatic logic [31:0] tick_diff(input logic [31:0] now, input logic [31:0] then);
		return now - then;
	endfunction

	function automatic logic [31:0] ticks_to_us(input logic [31:0] t);
		logic [34:0] p;
		p = {3'h0, t} * US_NUM;
		return 32'(p / US_DEN);
	endfunction

endpackage

// ==== rtl/pwm_edge.sv ====
/*
 Pin synchroniser and edge detector for all measured channels.
 Assumes pin inputs are asynchronous to pclk.
*/
`timescale 1ns/10ps
module pwm_edge import pwm_pkg::*; (
	// Clock, reset, enable
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           ce,
	// Pins
	input  wire logic [NCH-1:0] pin,
	// Synchronised view
	output logic      [NCH-1:0] level,
	output logic      [NCH-1:0] rise,
	output logic      [NCH-1:0] fall
);

	typedef struct packed {
		logic [NCH-1:0] s1;
		logic [NCH-1:0] s2;
		logic [NCH-1:0] s3;
	} pwm_edge_t;

	pwm_edge_t st;
	pwm_edge_t next_st;

	// ------------------------------------------------------------
	// Two-stage synchroniser, then one history stage
	// ------------------------------------------------------------
	always_comb begin
		next_st    = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Edges look only at settled stages, never at s1
	assign level = st.s2;
	assign rise  = st.s2 & ~st.s3;
	assign fall  = ~st.s2 & st.s3;

	// Level must trail the pin by exactly two enabled clocks
	property p_edge_level;
		@(posedge pclk) disable iff (!presetn)
		($past(presetn, 2) && $past(ce) && $past(ce, 2)) |-> (level == $past(pin, 2));
	endproperty
	a_edge_level: assert property (p_edge_level) else $error("level not pin two cycles late");

endmodule

// ==== test/pwm_pulse_src.sv ====
/*
 Behavioural pulse source standing in for receivers and sensors.
 Assumes the bench calls its tasks; pins move just after the rising clock edge.
*/
`timescale 1ns/10ps
module pwm_pulse_src import pwm_pkg::*; (
	// Clock reference
	input  wire logic           pclk,
	// Pins
	output logic      [NCH-1:0] pulse_in
);
	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	initial pulse_in = '0;

	// Just after the rising edge, so the sync delay is the same for every edge
	task automatic drive(input int ch, input logic v);
		@(posedge pclk);
		pulse_in[ch] <= v;
	endtask

	// High, low, high, then back low: both widths and both flags
	task automatic pulse(input int ch, input int h, input int l);
		drive(ch, 1'b1);
		repeat (h - 1) @(posedge pclk);
		drive(ch, 1'b0);
		repeat (l - 1) @(posedge pclk);
		drive(ch, 1'b1);
		repeat (h - 1) @(posedge pclk);
		drive(ch, 1'b0);
	endtask
endmodule

// ==== test/pwm_meter_tb.sv ====
/*
 Self-checking bench of the pulse width meter over APB.
 Assumes the tick advances once per clock and the slave answers within 20 cycles.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module pwm_meter_tb import pwm_pkg::*;;
	logic              pclk;
	logic              presetn;
	logic              ce;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [31:0]       tick_count = 32'hffff_ffe0;
	logic [NCH-1:0]    pulse_in;
	logic [31:0]       rd;
	logic [31:0]       ts;
	logic [31:0]       stamp;
	logic [31:0]       v;
	logic              err;
	int                err_count;
	int                samples_checked;
	int                ch;
	int                h;
	int                l;

	pwm_meter pwm_meter_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tick_count(tick_count), .pulse_in(pulse_in));
	pwm_pulse_src pwm_pulse_src_inst (.pclk(pclk), .pulse_in(pulse_in));

	// ------------------------------------------------------------
	// Clock, tick and bus tasks
	// ------------------------------------------------------------
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;
	always @(posedge pclk) tick_count <= tick_count + 32'h1;

	task final_report;
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		ts = tick_count;
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	function automatic logic [31:0] exp_us(input logic [31:0] t);
		return 32'((64'(t) * 64'd2) / 64'd5);
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		#2000000;
		err_count++;
		final_report();
	end

	initial begin
		presetn    = 1'b0;
		ce         = 1'b1;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = '0;
		pwdata     = '0;
		err_count  = 0;
		samples_checked = 0;
		void'($urandom(32'had7f));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(REG_CTRL, WORD_RST);
		apb(1'b0, 8'h3c, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, REG_CTRL, 32'h1);
		for (int i = 0; i < 5; i++) begin
			ch = (i == 0) ? 0 : (i == 1) ? NCH - 1 : $urandom_range(NCH - 1, 0);
			h = $urandom_range(20, 1);
			l = $urandom_range(20, 1);
			apb(1'b1, REG_CHSEL, 32'(ch));
			pwm_pulse_src_inst.pulse(ch, h, l);
			repeat (4) @(posedge pclk);
			apb(1'b1, REG_SNAP_CMD, 32'h1);
			rchk(REG_SNAP_HIGH, 32'(h));
			rchk(REG_SNAP_LOW, 32'(l));
			rchk(REG_SNAP_STATE, 32'h3);
			rchk(REG_FLAGS_ANY, 32'h0);
			apb(1'b0, REG_SNAP_STAMP, 32'h0);
			stamp = rd;
			apb(1'b0, REG_ELAPSED, 32'h0);
			`CHK(rd, ts - stamp)
			rchk(REG_LEVEL, 32'h0);
			pwm_pulse_src_inst.pulse(ch, h + 1, l + 2);
			repeat (4) @(posedge pclk);
			rchk(REG_HIGH_WIDTH, 32'(h + 1));
			rchk(REG_LOW_WIDTH, 32'(l + 2));
			rchk(REG_FLAGS_HIGH, 32'h3);
			rchk(REG_FLAGS_HIGH, 32'h0);
			rchk(REG_FLAGS_LOW, 32'h1);
			rchk(REG_FLAGS_LOW, 32'h0);
			pwm_pulse_src_inst.pulse(ch, h, l);
			repeat (4) @(posedge pclk);
			rchk(REG_FLAGS_ANY, 32'h3);
			rchk(REG_FLAGS_ANY, 32'h0);
			// Snapshot lands on the very edge that updates the record
			pwm_pulse_src_inst.drive(ch, 1'b1);
			@(posedge pclk);
			apb(1'b1, REG_SNAP_CMD, 32'h1);
			rchk(REG_SNAP_STATE, 32'h0);
			rchk(REG_FLAGS_ANY, 32'h1);
			rchk(REG_LEVEL, 32'h1);
			pwm_pulse_src_inst.drive(ch, 1'b0);
			repeat (4) @(posedge pclk);
		end
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'hffff_ffff : $urandom;
			apb(1'b1, REG_CONV, v);
			rchk(REG_CONV, exp_us(v));
		end
		// Stopped: edges must set no flags or widths in the record
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b1, REG_CHSEL, 32'h3);
		// Clock enable low: a write must leave no trace
		ce <= 1'b0;
		apb(1'b1, REG_CHSEL, 32'h5);
		ce <= 1'b1;
		rchk(REG_CHSEL, 32'h3);
		pwm_pulse_src_inst.pulse(3, 5, 5);
		repeat (4) @(posedge pclk);
		rchk(REG_FLAGS_ANY, 32'h0);
		rchk(REG_HIGH_WIDTH, 32'h0);
		final_report();
	end
endmodule
